/* core/mode_remap_pkg.sv */
// Package for the width-mode and I2C remap register bank.
// Assumes an 8-bit register port with byte offsets as index.
package mode_remap_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_WIDTH_MODE = 8'h05;
  localparam logic [7:0] ADDR_DESER_ADDRESS = 8'h06;
  localparam logic [7:0] ADDR_DESER_ALIAS = 8'h07;
  localparam logic [7:0] ADDR_TARGET_ADDRESS = 8'h08;
  localparam logic [7:0] ADDR_TARGET_ALIAS = 8'h09;
  localparam logic [7:0] ADDR_CRC_LOW = 8'h0A;
  localparam logic [7:0] ADDR_CRC_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_REVISION = 8'h0C;
  localparam logic [7:0] ADDR_REMAP_CTRL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h11;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h12;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h13;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_TEN = 0;
  localparam int BIT_TWELVE = 1;
  localparam int BIT_PIN_TEN = 2;
  localparam int BIT_PIN_TWELVE = 3;
  localparam int BIT_MODE_CURRENT = 4;
  localparam int BIT_OVERRIDE = 5;
  localparam int BIT_LOCK_ADDR = 0;
  localparam int BIT_FORWARD_EN = 2;
  localparam int BIT_REVISION_LSB = 5;
  localparam int IRQ_CRC_ERROR = 0;
  localparam int IRQ_ADDR_LOADED = 1;
  localparam int IRQ_REMAP_MISS = 2;
  localparam int IRQ_WIDTH = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_REMAP_CTRL = 8'h04;
  localparam logic [15:0] RESET_CRC_COUNT = 16'h0000;

  // Width mode, two-bit select in one-hot-ish form
  typedef enum logic [1:0] {
    WIDTH_NONE = 2'h0,
    WIDTH_TEN = 2'h1,
    WIDTH_TWELVE = 2'h2
  } width_type;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
  } i2c_head_type;

  typedef struct packed {
    logic hit;
    logic to_deser;
    logic [6:0] addr;
    logic rd;
  } remap_type;

endpackage

/* core/mode_remap_regs.sv */
// Width-mode select, I2C alias remap and back-channel CRC counter bank.
// Assumes pins and lock inputs come from other domains; I2C heads and
// CRC error pulses come from logic on ref_clk.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

// How it works
// - Mode bit 4 is a read-only flag showing the far-end mode is current, reset zero.
// - Mode bits 3 and 2 read one when the strapped twelve- or ten-bit mode is active.
// - Mode bit 1 turns twelve-bit transmit on or off, acting only while bit 5 is one.
// - Mode bit 0 turns ten-bit transmit on or off, acting only while bit 5 is one.
// - Deserializer address register bits 7:1 hold its address, and zero blocks it.
// - After receive lock the learned deserializer address is loaded unless locked.
// - Deserializer address bit 0 locks the address against reload, reset zero.
// - Heads matching the deserializer alias get the deserializer address; zero disables.
// - Target address bits 7:1 replace the address of heads that hit the target alias.
// - Target alias bits 7:1 pick the decoded address; zero alias or address disables.
// - Back-channel CRC errors seen while receive lock is held count into sixteen read-only bits over two bytes.
// - Mode bit 5 lets the software width bits override the far-end mode, reset zero.
// - Control bit 2, reset one, enables forwarding on both alias paths.
module mode_remap_regs #(
  parameter int CRC_WIDTH = 16,
  parameter logic [2:0] REVISION = 3'h0 // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Straps and link status, asynchronous
  input wire logic pin_twelve_bit,
  input wire logic pin_ten_bit,
  input wire logic rx_lock,
  // Back channel, same clock
  input wire logic [1:0] far_width_select,
  input wire logic far_width_valid,
  input wire logic [6:0] learned_deser_address,
  input wire logic crc_error,
  // Local I2C head to remap, same clock
  input wire logic head_valid,
  input wire mode_remap_pkg::i2c_head_type head_in,
  // Forwarded head, transmit mode and interrupt
  output mode_remap_pkg::remap_type head_out,
  output logic head_out_valid,
  output mode_remap_pkg::width_type tx_width,
  output logic irq
);

  // Counter is read as two bytes, so only sixteen bits fit the map
  if (CRC_WIDTH != 16) begin : g_width_check
    $error("CRC_WIDTH must be 16");
  end

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  logic [2:0] pin_sync [3];
  logic [2:0] pin_stable;
  logic [2:0] pin_raw;
  assign pin_raw = {rx_lock, pin_twelve_bit, pin_ten_bit};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_sync[i] <= 3'h0;
        pin_stable[i] <= 1'h0;
      end else if (clk_en) begin
        pin_sync[i] <= {pin_sync[i][1:0], pin_raw[i]};
        // Only second and third stage agreeing counts as a change
        if (pin_sync[i][2] == pin_sync[i][1]) begin
          pin_stable[i] <= pin_sync[i][2];
        end
      end
    end
  end

  logic pin_ten;
  logic pin_twelve;
  logic lock_level;
  logic lock_prev;
  assign pin_ten = pin_stable[0];
  assign pin_twelve = pin_stable[1];
  assign lock_level = pin_stable[2];

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] width_mode;
  logic [7:0] deser_address;
  logic [7:0] deser_alias;
  logic [7:0] target_address;
  logic [7:0] target_alias;
  logic [7:0] remap_ctrl;
  logic [CRC_WIDTH-1:0] crc_count;
  logic [1:0] far_width;
  logic mode_current;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] irq_event;

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = reg_wr && (reg_addr == a);
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      width_mode <= mode_remap_pkg::RESET_BYTE;
    end else if (clk_en && wr_hit(mode_remap_pkg::ADDR_WIDTH_MODE)) begin
      // Status bits 4:2 are not storage
      width_mode <= {reg_wdata[7:5], 3'h0, reg_wdata[1:0]};
    end
  end

  // Far-end mode and its freshness flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      far_width <= 2'h0;
      mode_current <= 1'h0;
    end else if (clk_en) begin
      if (far_width_valid) begin
        far_width <= far_width_select;
        mode_current <= 1'h1;
      end else if (!lock_level) begin
        mode_current <= 1'h0;
      end
    end
  end

  // Software bits under override, else far-end mode while current, else strap mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_width <= mode_remap_pkg::WIDTH_NONE;
    end else if (clk_en) begin
      if (width_mode[mode_remap_pkg::BIT_OVERRIDE]) begin
        // Both bits set is illegal; twelve-bit wins as a safe choice
        if (width_mode[mode_remap_pkg::BIT_TWELVE]) begin
          tx_width <= mode_remap_pkg::WIDTH_TWELVE;
        end else if (width_mode[mode_remap_pkg::BIT_TEN]) begin
          tx_width <= mode_remap_pkg::WIDTH_TEN;
        end else begin
          tx_width <= mode_remap_pkg::WIDTH_NONE;
        end
      end else if (mode_current) begin
        tx_width <= mode_remap_pkg::width_type'(far_width);
      end else if (pin_twelve) begin
        tx_width <= mode_remap_pkg::WIDTH_TWELVE;
      end else if (pin_ten) begin
        tx_width <= mode_remap_pkg::WIDTH_TEN;
      end else begin
        tx_width <= mode_remap_pkg::WIDTH_NONE;
      end
    end
  end

  // Deserializer address: software write or load after lock
  logic load_learned;
  assign load_learned = lock_level && !lock_prev
    && !deser_address[mode_remap_pkg::BIT_LOCK_ADDR];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deser_address <= mode_remap_pkg::RESET_BYTE;
      lock_prev <= 1'h0;
    end else if (clk_en) begin
      lock_prev <= lock_level;
      if (wr_hit(mode_remap_pkg::ADDR_DESER_ADDRESS)) begin
        deser_address <= reg_wdata;
      end else if (load_learned) begin
        deser_address <= {learned_deser_address, 1'h0};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deser_alias <= mode_remap_pkg::RESET_BYTE;
      target_address <= mode_remap_pkg::RESET_BYTE;
      target_alias <= mode_remap_pkg::RESET_BYTE;
      remap_ctrl <= mode_remap_pkg::RESET_REMAP_CTRL;
    end else if (clk_en) begin
      if (wr_hit(mode_remap_pkg::ADDR_DESER_ALIAS)) begin
        deser_alias <= reg_wdata;
      end
      if (wr_hit(mode_remap_pkg::ADDR_TARGET_ADDRESS)) begin
        target_address <= reg_wdata;
      end
      if (wr_hit(mode_remap_pkg::ADDR_TARGET_ALIAS)) begin
        target_alias <= reg_wdata;
      end
      if (wr_hit(mode_remap_pkg::ADDR_REMAP_CTRL)) begin
        remap_ctrl <= reg_wdata;
      end
    end
  end

  // ****************************************
  // Alias decode and remap
  // ****************************************
  logic deser_hit;
  logic target_hit;
  logic forward_en;
  assign forward_en = remap_ctrl[mode_remap_pkg::BIT_FORWARD_EN];
  assign deser_hit = forward_en && deser_alias[7:1] != 7'h00
    && deser_address[7:1] != 7'h00
    && head_in.addr == deser_alias[7:1];
  assign target_hit = forward_en && target_alias[7:1] != 7'h00
    && target_address[7:1] != 7'h00
    && head_in.addr == target_alias[7:1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_out <= '0;
      head_out_valid <= 1'h0;
    end else if (clk_en) begin
      head_out_valid <= head_valid && (deser_hit || target_hit);
      head_out.rd <= head_in.rd;
      head_out.hit <= head_valid && (deser_hit || target_hit);
      head_out.to_deser <= deser_hit;
      // Deserializer alias takes priority when both aliases match
      if (deser_hit) begin
        head_out.addr <= deser_address[7:1];
      end else if (target_hit) begin
        head_out.addr <= target_address[7:1];
      end else begin
        head_out.addr <= head_in.addr;
      end
    end
  end

  // ****************************************
  // CRC error counter
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_count <= mode_remap_pkg::RESET_CRC_COUNT;
    end else if (clk_en && crc_error && lock_level) begin
      // Saturates so a long error burst never wraps to a small count
      if (crc_count != {CRC_WIDTH{1'b1}}) begin
        crc_count <= crc_count + 16'h0001;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_event[mode_remap_pkg::IRQ_CRC_ERROR] = crc_error && lock_level;
  assign irq_event[mode_remap_pkg::IRQ_ADDR_LOADED] = load_learned;
  assign irq_event[mode_remap_pkg::IRQ_REMAP_MISS] = head_valid && !(deser_hit || target_hit);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 3'h0;
      irq_enable <= 3'h0;
      irq <= 1'h0;
    end else if (clk_en) begin
      if (wr_hit(mode_remap_pkg::ADDR_IRQ_ENABLE)) begin
        irq_enable <= reg_wdata[2:0];
      end
      // Set wins over a clear in the same cycle
      if (wr_hit(mode_remap_pkg::ADDR_IRQ_CLEAR)) begin
        irq_status <= (irq_status & ~reg_wdata[2:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      irq <= |(irq_status & irq_enable);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [7:0] mode_read;
  assign mode_read = {width_mode[7:5], mode_current, pin_twelve, pin_ten,
    width_mode[1:0]};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          mode_remap_pkg::ADDR_WIDTH_MODE: reg_rdata <= mode_read;
          mode_remap_pkg::ADDR_DESER_ADDRESS: reg_rdata <= deser_address;
          mode_remap_pkg::ADDR_DESER_ALIAS: reg_rdata <= deser_alias;
          mode_remap_pkg::ADDR_TARGET_ADDRESS: reg_rdata <= target_address;
          mode_remap_pkg::ADDR_TARGET_ALIAS: reg_rdata <= target_alias;
          mode_remap_pkg::ADDR_CRC_LOW: reg_rdata <= crc_count[7:0];
          mode_remap_pkg::ADDR_CRC_HIGH: reg_rdata <= crc_count[15:8];
          mode_remap_pkg::ADDR_REVISION: reg_rdata <= {REVISION, 5'h00};
          mode_remap_pkg::ADDR_REMAP_CTRL: reg_rdata <= remap_ctrl;
          mode_remap_pkg::ADDR_IRQ_STATUS: reg_rdata <= {5'h00, irq_status};
          mode_remap_pkg::ADDR_IRQ_ENABLE: reg_rdata <= {5'h00, irq_enable};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_override_twelve: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && width_mode[5] && width_mode[1] |=> tx_width == mode_remap_pkg::WIDTH_TWELVE)
    else $error("override twelve-bit not applied");
  a_override_ten: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && width_mode[5:0] == 6'h21 |=> tx_width == mode_remap_pkg::WIDTH_TEN)
    else $error("override ten-bit not applied");
  a_no_override: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !width_mode[5] && !mode_current && pin_twelve
    |=> tx_width == mode_remap_pkg::WIDTH_TWELVE)
    else $error("strap mode ignored without override");
  a_current_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && far_width_valid |=> mode_current)
    else $error("mode current flag not set");
  a_frozen_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && deser_address[0] && !reg_wr |=> $stable(deser_address))
    else $error("locked address changed");
  a_learned_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && load_learned && !reg_wr
    |=> deser_address[7:1] == $past(learned_deser_address))
    else $error("learned address not loaded");
  a_deser_remap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && head_valid && deser_hit
    |=> head_out_valid && head_out.addr == $past(deser_address[7:1]))
    else $error("deserializer alias not remapped");
  a_zero_alias: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && head_valid && target_alias[7:1] == 7'h00 && !deser_hit |=> !head_out_valid)
    else $error("zero target alias forwarded");
  a_crc_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && crc_error && lock_level && crc_count != 16'hFFFF
    |=> crc_count == $past(crc_count) + 16'h0001)
    else $error("crc error not counted");

endmodule

/* dv/remote_deser_model.sv */
// Remote deserializer model on the far side of the back channel.
// Assumes bench requests change right after a rising edge of ref_clk.
`timescale 1ns/1ps
module remote_deser_model #(
  parameter logic [6:0] LEARNED = 7'h3A
) (
  // Clock and bench requests
  input wire logic ref_clk,
  input wire logic link_up,
  input wire logic mode_go,
  input wire logic [1:0] mode_val,
  input wire logic err_go,
  // Back channel toward the block
  output logic rx_lock,
  output logic [1:0] far_width_select,
  output logic far_width_valid,
  output logic [6:0] learned_deser_address,
  output logic crc_error
);
  // ****************************************
  // Channel drive
  // ****************************************
  initial begin
    rx_lock = 1'b0;
    far_width_select = 2'h0;
    far_width_valid = 1'b0;
    learned_deser_address = 7'h00;
    crc_error = 1'b0;
  end
  always @(posedge ref_clk) begin
    rx_lock <= link_up;
    far_width_valid <= mode_go;
    // Outside a mode pulse the select lines carry no meaning: keep them moving
    far_width_select <= mode_go ? mode_val : ~far_width_select;
    crc_error <= err_go;
    learned_deser_address <= link_up ? LEARNED : ~learned_deser_address;
  end
endmodule

/* dv/serializer_mode_and_i2c_remap_regs_bench.sv */
// Self-checking bench for the width-mode and I2C remap register bank.
// Assumes the remote deserializer model drives the back channel.
`timescale 1ns/1ps
module serializer_mode_and_i2c_remap_regs_bench;
  localparam logic [6:0] LEARN = 7'h3A;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_en = 1'b1;
  logic pin_twelve_bit = 1'b0;
  logic pin_ten_bit = 1'b0;
  logic link_up = 1'b0;
  logic mode_go = 1'b0;
  logic [1:0] mode_val = 2'h0;
  logic err_go = 1'b0;
  logic head_valid = 1'b0;
  mode_remap_pkg::i2c_head_type head_in = '0;
  mode_remap_pkg::remap_type head_out;
  mode_remap_pkg::width_type tx_width;
  logic [7:0] reg_rdata;
  logic head_out_valid, irq, rx_lock, far_width_valid, crc_error;
  logic [1:0] far_width_select;
  logic [6:0] learned_deser_address;
  logic [7:0] d, dal, dad, tal, tad, fwd;
  logic [7:0] mv [4] = '{8'h21, 8'h22, 8'h02, 8'h1D};
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  mode_remap_regs mode_remap_regs_inst (.ref_clk, .arst_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_twelve_bit, .pin_ten_bit, .rx_lock,
    .far_width_select, .far_width_valid, .learned_deser_address, .crc_error,
    .head_valid, .head_in, .head_out, .head_out_valid, .tx_width, .irq);
  remote_deser_model #(.LEARNED(LEARN)) remote_deser_model_inst (.ref_clk, .link_up,
    .mode_go, .mode_val, .err_go, .rx_lock, .far_width_select, .far_width_valid,
    .learned_deser_address, .crc_error);
  // ****************************************
  // Checks and bus tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bad(string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_reg(logic [7:0] g, logic [7:0] e, string m);
    checks_done++;
    if (g !== e) bad(m);
  endtask
  task automatic chk_bit(logic g, logic e, string m);
    checks_done++;
    if (g !== e) bad(m);
  endtask
  task automatic chk_width(mode_remap_pkg::width_type g, mode_remap_pkg::width_type e);
    checks_done++;
    if (g !== e) bad("tx width");
  endtask
  task automatic chk_head(logic v, logic [9:0] g, logic [10:0] e);
    checks_done++;
    if (v !== e[10] || (e[10] && g !== e[9:0])) bad("remap");
  endtask
  function automatic logic [10:0] exp_head(logic [6:0] a, logic r);
    if (fwd[2] && dal[7:1] != 7'h00 && dad[7:1] != 7'h00 && a == dal[7:1])
      return {3'h7, dad[7:1], r};
    if (fwd[2] && tal[7:1] != 7'h00 && tad[7:1] != 7'h00 && a == tal[7:1])
      return {3'h6, tad[7:1], r};
    return 11'h000;
  endfunction
  function automatic mode_remap_pkg::width_type exp_width(logic [7:0] m, logic c, logic [1:0] f);
    if (m[5] && m[1]) return mode_remap_pkg::WIDTH_TWELVE;
    if (m[5] && m[0]) return mode_remap_pkg::WIDTH_TEN;
    if (c) return mode_remap_pkg::width_type'(f);
    if (pin_twelve_bit) return mode_remap_pkg::WIDTH_TWELVE;
    if (pin_ten_bit) return mode_remap_pkg::WIDTH_TEN;
    return mode_remap_pkg::WIDTH_NONE;
  endfunction
  task automatic idle(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic mode_check(logic [7:0] m, logic c, logic [1:0] f);
    rd(mode_remap_pkg::ADDR_WIDTH_MODE);
    chk_reg(d, {2'h0, m[5], c, pin_twelve_bit, pin_ten_bit, m[1:0]}, "mode reg");
    chk_width(tx_width, exp_width(m, c, f));
  endtask
  task automatic head(logic [6:0] a, logic r);
    @(posedge ref_clk);
    head_valid <= 1'b1;
    head_in <= '{addr: a, rd: r};
    @(posedge ref_clk);
    head_valid <= 1'b0;
    #1 chk_head(head_out_valid, head_out, exp_head(a, r));
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad("timeout");
      complete_run();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    void'($urandom(93));
    fwd = 8'h04;
    idle(6);
    arst_n <= 1'b1;
    idle(3);
    for (int i = 5; i < 13; i++) begin
      rd(8'(i));
      chk_reg(d, 8'h00, "reset value");
    end
    rd(mode_remap_pkg::ADDR_REMAP_CTRL);
    chk_reg(d, 8'h04, "forward reset");
    rd(8'h20);
    chk_reg(d, 8'h00, "unmapped");
    // A write while the enable is low must leave no trace
    clk_en <= 1'b0;
    wr(mode_remap_pkg::ADDR_TARGET_ALIAS, 8'hFE);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(mode_remap_pkg::ADDR_TARGET_ALIAS);
    chk_reg(d, 8'h00, "frozen by enable");
    $display("test reset done");
    pin_twelve_bit <= 1'b1;
    idle(8);
    mode_check(8'h00, 1'b0, 2'h0);
    pin_twelve_bit <= 1'b0;
    pin_ten_bit <= 1'b1;
    idle(8);
    mode_check(8'h00, 1'b0, 2'h0);
    foreach (mv[i]) begin
      wr(mode_remap_pkg::ADDR_WIDTH_MODE, mv[i]);
      idle(3);
      mode_check(mv[i], 1'b0, 2'h0);
    end
    wr(mode_remap_pkg::ADDR_WIDTH_MODE, 8'h00);
    $display("test mode done");
    link_up <= 1'b1;
    idle(12);
    rd(mode_remap_pkg::ADDR_DESER_ADDRESS);
    chk_reg(d, {LEARN, 1'h0}, "learned");
    mode_val <= 2'h2;
    mode_go <= 1'b1;
    @(posedge ref_clk);
    mode_go <= 1'b0;
    idle(4);
    mode_check(8'h00, 1'b1, 2'h2);
    wr(mode_remap_pkg::ADDR_WIDTH_MODE, 8'h21);
    idle(3);
    mode_check(8'h21, 1'b1, 2'h2);
    wr(mode_remap_pkg::ADDR_WIDTH_MODE, 8'h00);
    dad = 8'h55;
    wr(mode_remap_pkg::ADDR_DESER_ADDRESS, dad);
    link_up <= 1'b0;
    idle(12);
    mode_check(8'h00, 1'b0, 2'h0);
    link_up <= 1'b1;
    idle(12);
    rd(mode_remap_pkg::ADDR_DESER_ADDRESS);
    chk_reg(d, dad, "frozen");
    $display("test lock done");
    dal = {7'($urandom_range(1, 63)), 1'h0};
    tal = {7'($urandom_range(64, 127)), 1'h0};
    tad = {7'($urandom_range(1, 127)), 1'h0};
    wr(mode_remap_pkg::ADDR_DESER_ALIAS, dal);
    wr(mode_remap_pkg::ADDR_TARGET_ALIAS, tal);
    wr(mode_remap_pkg::ADDR_TARGET_ADDRESS, tad);
    head(dal[7:1], 1'b1);
    head(tal[7:1], 1'b0);
    repeat (8) head(7'($urandom), 1'($urandom));
    n = tad;
    tad = 8'h00;
    wr(mode_remap_pkg::ADDR_TARGET_ADDRESS, tad);
    head(tal[7:1], 1'b0);
    tad = 8'(n);
    wr(mode_remap_pkg::ADDR_TARGET_ADDRESS, tad);
    n = tal;
    tal = 8'h00;
    wr(mode_remap_pkg::ADDR_TARGET_ALIAS, tal);
    head(7'(n >> 1), 1'b0);
    dad = 8'h01;
    wr(mode_remap_pkg::ADDR_DESER_ADDRESS, dad);
    head(dal[7:1], 1'b1);
    dad = 8'h55;
    wr(mode_remap_pkg::ADDR_DESER_ADDRESS, dad);
    fwd = 8'h00;
    wr(mode_remap_pkg::ADDR_REMAP_CTRL, fwd);
    head(dal[7:1], 1'b1);
    $display("test remap done");
    n = $urandom_range(3, 40);
    repeat (n) begin
      err_go <= 1'b1;
      @(posedge ref_clk);
      err_go <= 1'b0;
      @(posedge ref_clk);
    end
    idle(3);
    rd(mode_remap_pkg::ADDR_CRC_LOW);
    chk_reg(d, 8'(n), "crc low");
    rd(mode_remap_pkg::ADDR_CRC_HIGH);
    chk_reg(d, 8'h00, "crc high");
    rd(mode_remap_pkg::ADDR_IRQ_STATUS);
    chk_reg(d, 8'h07, "irq status");
    wr(mode_remap_pkg::ADDR_IRQ_ENABLE, 8'h01);
    idle(3);
    #1 chk_bit(irq, 1'b1, "irq set");
    wr(mode_remap_pkg::ADDR_IRQ_ENABLE, 8'h00);
    idle(3);
    #1 chk_bit(irq, 1'b0, "irq masked");
    wr(mode_remap_pkg::ADDR_IRQ_ENABLE, 8'h01);
    wr(mode_remap_pkg::ADDR_IRQ_CLEAR, 8'h07);
    idle(3);
    #1 chk_bit(irq, 1'b0, "irq cleared");
    rd(mode_remap_pkg::ADDR_IRQ_STATUS);
    chk_reg(d, 8'h00, "status cleared");
    $display("test crc done");
    complete_run();
  end
endmodule
